// *** logic/dacl_pkg.sv ***
// Constants, register map and types for the parallel converter load controller
package dacl_pkg;

  // ------------------------------------------------------------
  // Clock and pin timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int LOAD_HIGH_MIN_NS   = 40;
  localparam int LOAD_LOW_MIN_NS    = 40;
  localparam int LOAD_SETUP_MIN_NS  = 10;
  localparam int BUS_WRITE_NS       = 40;
  localparam int BUS_READ_NS        = 60;
  localparam int CLEAR_PULSE_NS     = 100;
  localparam int WAKE_5V_NS         = 2500;
  localparam int WAKE_3V_NS         = 5000;

  // Least times round up, never below one cycle
  function automatic int ns_to_cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int LOAD_HIGH_CYC  = ns_to_cyc_up(LOAD_HIGH_MIN_NS);
  localparam int LOAD_LOW_CYC   = (ns_to_cyc_up(LOAD_LOW_MIN_NS) > ns_to_cyc_up(LOAD_SETUP_MIN_NS))
                                  ? ns_to_cyc_up(LOAD_LOW_MIN_NS) : ns_to_cyc_up(LOAD_SETUP_MIN_NS);
  localparam int BUS_WRITE_CYC  = ns_to_cyc_up(BUS_WRITE_NS);
  localparam int BUS_READ_CYC   = ns_to_cyc_up(BUS_READ_NS);
  localparam int CLEAR_CYC      = ns_to_cyc_up(CLEAR_PULSE_NS);
  localparam int WAKE_5V_CYC    = ns_to_cyc_up(WAKE_5V_NS);
  localparam int WAKE_3V_CYC    = ns_to_cyc_up(WAKE_3V_NS);
  localparam int TMR_W          = 10;

  // ------------------------------------------------------------
  // Register map (word index on the Avalon address)
  // ------------------------------------------------------------
  localparam int          ADDR_W       = 3;
  localparam logic [2:0]  ADDR_CTRL    = 3'h0;
  localparam logic [2:0]  ADDR_DATA    = 3'h1;
  localparam logic [2:0]  ADDR_CMD     = 3'h2;
  localparam logic [2:0]  ADDR_STATUS  = 3'h3;
  localparam logic [2:0]  ADDR_RDATA   = 3'h4;

  localparam int          WORD_W       = 16;
  localparam int          CTRL_W       = 6;
  localparam logic [5:0]  CTRL_RESET   = 6'h00;
  localparam logic [15:0] DATA_RESET   = 16'h0000;
  localparam int          CTRL_FMT_BIT    = 0;
  localparam int          CTRL_CLRLVL_BIT = 1;
  localparam int          CTRL_SLEEP_LO   = 2;
  localparam int          CTRL_SLEEP_HI   = 3;
  localparam int          CTRL_AUTOLD_BIT = 4;
  localparam int          CTRL_SUP5_BIT   = 5;
  localparam int          CMD_LOAD_BIT    = 0;
  localparam int          CMD_READ_BIT    = 1;
  localparam int          CMD_CLEAR_BIT   = 2;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_WAKE_BIT   = 1;
  localparam int          STAT_RDV_BIT    = 2;

  typedef enum logic [2:0] {
    DACL_IDLE, DACL_CLEAR, DACL_WR, DACL_WR_END, DACL_LD_LOW, DACL_LD_HIGH, DACL_RD
  } dacl_seq_e;

endpackage

// *** logic/dacl_timer.sv ***
// Phase timer: loaded with a count, reports expiry when it reaches zero
`timescale 1ns/1ps
`default_nettype none
module dacl_timer
  import dacl_pkg::*;
#(
  parameter int W = TMR_W
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         start,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  if (W < 2) begin : g_chk
    $error("dacl_timer: W must be at least 2");
  end

  always_comb begin
    cnt_next = cnt_reg;
    if (start) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign expired = (cnt_reg == '0);

endmodule
`default_nettype wire

// *** logic/dacl_wake_guard.sv ***
// Tracks the recovery time after the converter leaves a sleep mode
`timescale 1ns/1ps
`default_nettype none
module dacl_wake_guard
  import dacl_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] sleep_mode,
  input  wire logic       supply_5v,
  output logic            wake_busy
);

  logic             asleep_reg;
  logic             asleep_next;
  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;

  if (WAKE_3V_CYC >= (1 << TMR_W)) begin : g_chk
    $error("dacl_wake_guard: TMR_W too small for wake time");
  end

  // Waking takes longer on the low analog supply
  always_comb begin
    asleep_next = (sleep_mode != 2'h0);
    cnt_next    = cnt_reg;
    if (asleep_reg && !asleep_next) begin
      cnt_next = supply_5v ? TMR_W'(WAKE_5V_CYC) : TMR_W'(WAKE_3V_CYC);
    end else if (asleep_next) begin
      cnt_next = '0;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      asleep_reg <= 1'b0;
      cnt_reg    <= '0;
    end else begin
      asleep_reg <= asleep_next;
      cnt_reg    <= cnt_next;
    end
  end

  assign wake_busy = (cnt_reg != '0);

endmodule
`default_nettype wire

// *** logic/dacl_host_ctrl.sv ***
// Host-side controller driving a 16-bit parallel converter from Avalon-MM registers
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dacl_host_ctrl
  import dacl_pkg::*;
#(
  parameter int DATA_W = WORD_W
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Converter pins
  output logic                   conv_cs_n,
  output logic                   conv_rw,
  output logic [DATA_W-1:0]      conv_data_out,
  output logic                   conv_data_oe,
  input  wire logic [DATA_W-1:0] conv_data_in,
  output logic                   output_load_strobe,
  output logic                   conv_clear_n,
  output logic                   clear_level_select,
  output logic                   sleep_sel_lo,
  output logic                   sleep_sel_hi,
  output logic                   code_format_sel
);

  if (DATA_W != WORD_W) begin : g_chk
    $error("dacl_host_ctrl: DATA_W must equal the converter word width");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_seq_addr(input logic [ADDR_W-1:0] a);
    return (a == ADDR_DATA) || (a == ADDR_CMD);
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] data_next;
  logic              waitreq_reg;
  logic              waitreq_next;
  logic [31:0]       readdata_reg;
  logic [31:0]       readdata_next;

  dacl_seq_e         state_reg;
  dacl_seq_e         state_next;
  logic              pend_wr_reg, pend_wr_next;
  logic              pend_ld_reg, pend_ld_next;
  logic              pend_rd_reg, pend_rd_next;
  logic              pend_clr_reg, pend_clr_next;
  logic              cs_n_reg, cs_n_next;
  logic              rw_reg, rw_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic              oe_reg, oe_next;
  logic              strobe_reg, strobe_next;
  logic              clr_n_reg, clr_n_next;
  logic [DATA_W-1:0] rword_reg, rword_next;
  logic              rvalid_reg, rvalid_next;

  logic              req;
  logic              busy;
  logic              grant;
  logic              commit_wr;
  logic              commit_rd;
  logic              tmr_start;
  logic [TMR_W-1:0]  tmr_val;
  logic              tmr_expired;
  logic              wake_busy;
  logic [31:0]       merged;

  assign req  = avs_read || avs_write;
  assign busy = pend_wr_reg || pend_ld_reg || pend_rd_reg || pend_clr_reg
                || (state_reg != DACL_IDLE);
  // Sequencer writes stall while a pin cycle is queued or running
  assign grant     = req && waitreq_reg && !(avs_write && is_seq_addr(avs_address) && busy);
  assign commit_wr = avs_write && !waitreq_reg;
  assign commit_rd = avs_read && !waitreq_reg;
  assign merged    = be_merge((avs_address == ADDR_CTRL) ? {26'h0, ctrl_reg} : {16'h0, data_reg},
                              avs_writedata, avs_byteenable);

  // ------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------
  always_comb begin
    ctrl_next     = ctrl_reg;
    data_next     = data_reg;
    waitreq_next  = !grant;
    readdata_next = readdata_reg;
    if (grant && avs_read) begin
      case (avs_address)
        ADDR_CTRL:   readdata_next = {26'h0, ctrl_reg};
        ADDR_DATA:   readdata_next = {16'h0, data_reg};
        ADDR_STATUS: readdata_next = {29'h0, rvalid_reg, wake_busy, busy};
        ADDR_RDATA:  readdata_next = {16'h0, rword_reg};
        default:     readdata_next = 32'h0;
      endcase
    end
    if (commit_wr) begin
      case (avs_address)
        ADDR_CTRL: ctrl_next = merged[CTRL_W-1:0];
        ADDR_DATA: data_next = merged[DATA_W-1:0];
        default:   ctrl_next = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_reg     <= CTRL_RESET;
      data_reg     <= DATA_RESET;
      waitreq_reg  <= 1'b1;
      readdata_reg <= 32'h0;
    end else begin
      ctrl_reg     <= ctrl_next;
      data_reg     <= data_next;
      waitreq_reg  <= waitreq_next;
      readdata_reg <= readdata_next;
    end
  end

  // ------------------------------------------------------------
  // Pin sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    pend_wr_next  = pend_wr_reg;
    pend_ld_next  = pend_ld_reg;
    pend_rd_next  = pend_rd_reg;
    pend_clr_next = pend_clr_reg;
    cs_n_next     = cs_n_reg;
    rw_next       = rw_reg;
    dout_next     = dout_reg;
    oe_next       = oe_reg;
    strobe_next   = strobe_reg;
    clr_n_next    = clr_n_reg;
    rword_next    = rword_reg;
    rvalid_next   = rvalid_reg;
    tmr_start     = 1'b0;
    tmr_val       = '0;
    if (commit_rd && (avs_address == ADDR_RDATA)) begin
      rvalid_next = 1'b0;
    end
    case (state_reg)
      DACL_IDLE: begin
        // New pin cycles wait out the wake time after sleep; they are not held while a sleep mode is set
        if (!wake_busy) begin
          if (pend_clr_reg) begin
            pend_clr_next = 1'b0;
            clr_n_next    = 1'b0;
            tmr_start     = 1'b1;
            tmr_val       = TMR_W'(CLEAR_CYC - 1);
            state_next    = DACL_CLEAR;
          end else if (pend_wr_reg) begin
            pend_wr_next = 1'b0;
            cs_n_next    = 1'b0;
            rw_next      = 1'b0;
            dout_next    = data_reg;
            oe_next      = 1'b1;
            tmr_start    = 1'b1;
            tmr_val      = TMR_W'(BUS_WRITE_CYC - 1);
            state_next   = DACL_WR;
          end else if (pend_ld_reg) begin
            pend_ld_next = 1'b0;
            tmr_start    = 1'b1;
            tmr_val      = TMR_W'(LOAD_LOW_CYC - 1);
            state_next   = DACL_LD_LOW;
          end else if (pend_rd_reg) begin
            pend_rd_next = 1'b0;
            cs_n_next    = 1'b0;
            rw_next      = 1'b1;
            oe_next      = 1'b0;
            tmr_start    = 1'b1;
            tmr_val      = TMR_W'(BUS_READ_CYC - 1);
            state_next   = DACL_RD;
          end
        end
      end
      DACL_CLEAR: begin
        if (tmr_expired) begin
          clr_n_next = 1'b1;
          state_next = DACL_IDLE;
        end
      end
      DACL_WR: begin
        if (tmr_expired) begin
          cs_n_next  = 1'b1;
          state_next = DACL_WR_END;
        end
      end
      DACL_WR_END: begin
        // Data held one cycle past the select release
        oe_next    = 1'b0;
        rw_next    = 1'b1;
        state_next = DACL_IDLE;
      end
      DACL_LD_LOW: begin
        // Low phase also covers the data setup before the rising edge
        if (tmr_expired) begin
          strobe_next = 1'b1;
          tmr_start   = 1'b1;
          tmr_val     = TMR_W'(LOAD_HIGH_CYC - 1);
          state_next  = DACL_LD_HIGH;
        end
      end
      DACL_LD_HIGH: begin
        if (tmr_expired) begin
          strobe_next = 1'b0;
          state_next  = DACL_IDLE;
        end
      end
      DACL_RD: begin
        if (tmr_expired) begin
          rword_next  = conv_data_in;
          rvalid_next = 1'b1;
          cs_n_next   = 1'b1;
          state_next  = DACL_IDLE;
        end
      end
      default: begin
        state_next = DACL_IDLE;
      end
    endcase
    if (commit_wr && (avs_address == ADDR_DATA)) begin
      pend_wr_next = 1'b1;
      pend_ld_next = ctrl_reg[CTRL_AUTOLD_BIT];
    end
    if (commit_wr && (avs_address == ADDR_CMD)) begin
      pend_ld_next  = avs_byteenable[0] && avs_writedata[CMD_LOAD_BIT];
      pend_rd_next  = avs_byteenable[0] && avs_writedata[CMD_READ_BIT];
      pend_clr_next = avs_byteenable[0] && avs_writedata[CMD_CLEAR_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg    <= DACL_IDLE;
      pend_wr_reg  <= 1'b0;
      pend_ld_reg  <= 1'b0;
      pend_rd_reg  <= 1'b0;
      pend_clr_reg <= 1'b0;
      cs_n_reg     <= 1'b1;
      rw_reg       <= 1'b1;
      dout_reg     <= DATA_RESET;
      oe_reg       <= 1'b0;
      strobe_reg   <= 1'b0;
      clr_n_reg    <= 1'b1;
      rword_reg    <= DATA_RESET;
      rvalid_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      pend_wr_reg  <= pend_wr_next;
      pend_ld_reg  <= pend_ld_next;
      pend_rd_reg  <= pend_rd_next;
      pend_clr_reg <= pend_clr_next;
      cs_n_reg     <= cs_n_next;
      rw_reg       <= rw_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
      strobe_reg   <= strobe_next;
      clr_n_reg    <= clr_n_next;
      rword_reg    <= rword_next;
      rvalid_reg   <= rvalid_next;
    end
  end

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  dacl_timer #(
    .W        (TMR_W)
  ) u_phase_timer (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .start    (tmr_start),
    .load_val (tmr_val),
    .expired  (tmr_expired)
  );

  dacl_wake_guard u_wake_guard (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .sleep_mode ({ctrl_reg[CTRL_SLEEP_HI], ctrl_reg[CTRL_SLEEP_LO]}),
    .supply_5v  (ctrl_reg[CTRL_SUP5_BIT]),
    .wake_busy  (wake_busy)
  );

  // ------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ------------------------------------------------------------
  assign avs_readdata       = readdata_reg;
  assign avs_waitrequest    = waitreq_reg;
  assign conv_cs_n          = cs_n_reg;
  assign conv_rw            = rw_reg;
  assign conv_data_out      = dout_reg;
  assign conv_data_oe       = oe_reg;
  assign output_load_strobe = strobe_reg;
  assign conv_clear_n       = clr_n_reg;
  assign clear_level_select = ctrl_reg[CTRL_CLRLVL_BIT];
  assign sleep_sel_lo       = ctrl_reg[CTRL_SLEEP_LO];
  assign sleep_sel_hi       = ctrl_reg[CTRL_SLEEP_HI];
  assign code_format_sel    = ctrl_reg[CTRL_FMT_BIT];

endmodule
`default_nettype wire

// *** verification/dacl_ctrl_asserts.sv ***
// Pin and bus protocol checker for the converter load controller
`timescale 1ns/1ps
`default_nettype none
module dacl_ctrl_asserts
  import dacl_pkg::*;
#(
  parameter int DATA_W = WORD_W
) (
  input wire logic              core_clk,
  input wire logic              reset_n,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest,
  input wire logic              conv_cs_n,
  input wire logic              conv_rw,
  input wire logic [DATA_W-1:0] conv_data_out,
  input wire logic              conv_data_oe,
  input wire logic              output_load_strobe,
  input wire logic              conv_clear_n,
  input wire logic              sleep_sel_lo,
  input wire logic              sleep_sel_hi
);
  // --------
  // Helper counters
  // --------
  logic [2:0] low_run_reg, low_run_next;
  logic [8:0] wake_reg, wake_next;
  logic [1:0] sleep_reg, sleep_next;
  always_comb begin
    sleep_next = {sleep_sel_hi, sleep_sel_lo};
    low_run_next = (low_run_reg == 3'h7) ? low_run_reg : low_run_reg + 3'h1;
    if (output_load_strobe) low_run_next = 3'h0;
    wake_next = (wake_reg != 9'h000) ? wake_reg - 9'h001 : 9'h000;
    // Shortest wake less one cycle, since the pins lag the guard by one
    if (sleep_reg != 2'h0 && sleep_next == 2'h0) wake_next = 9'h0F9;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      low_run_reg <= 3'h0;
      wake_reg    <= 9'h000;
      sleep_reg   <= 2'h0;
    end else begin
      low_run_reg <= low_run_next;
      wake_reg    <= wake_next;
      sleep_reg   <= sleep_next;
    end
  end
  // --------
  // Properties
  // --------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_clear_low;
    !conv_clear_n [*8] ##1 !conv_clear_n [*2];
  endsequence
  sequence s_write_walk;
    (!conv_cs_n && conv_data_oe) ##1 (!conv_cs_n && conv_data_oe && $stable(conv_data_out)) [*3]
      ##1 (conv_cs_n && conv_data_oe && $stable(conv_data_out));
  endsequence
  sequence s_read_walk;
    (!conv_cs_n && conv_rw && !conv_data_oe) [*6] ##1 conv_cs_n;
  endsequence
  a_clear_pulse_len: assert property ($fell(conv_clear_n) |-> s_clear_low ##1 conv_clear_n)
    else $error("clear pulse length wrong");
  a_write_data_held: assert property (($fell(conv_cs_n) && !conv_rw) |-> s_write_walk)
    else $error("write cycle data not held");
  a_read_bus_free: assert property (($fell(conv_cs_n) && conv_rw) |-> s_read_walk)
    else $error("read cycle shape wrong");
  a_strobe_high_len: assert property ($rose(output_load_strobe) |-> output_load_strobe [*4]
    ##1 !output_load_strobe)
    else $error("strobe high time wrong");
  a_strobe_low_len: assert property ($rose(output_load_strobe) |-> low_run_reg >= 3'h4)
    else $error("strobe low time too short");
  a_strobe_no_sel: assert property (output_load_strobe |-> conv_cs_n)
    else $error("strobe high during bus cycle");
  a_dir_idle_read: assert property (!conv_data_oe |-> conv_rw)
    else $error("direction low while bus released");
  a_wake_no_ops: assert property (($fell(conv_cs_n) || $rose(output_load_strobe))
    |-> wake_reg == 9'h000)
    else $error("pin operation during wake time");
  a_wait_one_cyc: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_has_req: assert property (!avs_waitrequest |-> (avs_read || avs_write))
    else $error("answer without request");
endmodule
bind dacl_host_ctrl dacl_ctrl_asserts #(.DATA_W(DATA_W)) dacl_ctrl_asserts_inst (
  .core_clk(core_clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .conv_cs_n(conv_cs_n), .conv_rw(conv_rw),
  .conv_data_out(conv_data_out), .conv_data_oe(conv_data_oe),
  .output_load_strobe(output_load_strobe), .conv_clear_n(conv_clear_n),
  .sleep_sel_lo(sleep_sel_lo), .sleep_sel_hi(sleep_sel_hi));
`default_nettype wire

// *** verification/dacl_conv_model.sv ***
// Behavioural model of the parallel-input converter
`timescale 1ns/1ps
`default_nettype none
module dacl_conv_model
  import dacl_pkg::*;
(
  input  wire logic              cs_n,
  input  wire logic              rw,
  input  wire logic [WORD_W-1:0] host_data,
  input  wire logic              host_oe,
  output logic      [WORD_W-1:0] bus_level,
  input  wire logic              load_strobe,
  input  wire logic              clear_n,
  input  wire logic              clear_mid,
  input  wire logic              sleep_lo,
  input  wire logic              sleep_hi,
  input  wire logic              twos_fmt,
  output logic      [WORD_W-1:0] hold_word,
  output logic      [WORD_W-1:0] out_level,
  output logic                   out_connected
);
  logic [WORD_W-1:0] last_word;
  initial begin
    hold_word = 16'h0000;
    out_level = 16'h0000;
    last_word = 16'h0000;
  end
  // Level is straight binary, so a twos-complement word moves by half scale
  always @(posedge load_strobe) out_level = twos_fmt ? hold_word ^ 16'h8000 : hold_word;
  always @(negedge clear_n) out_level = clear_mid ? 16'h8000 : 16'h0000;
  always @(posedge cs_n) if (!rw) hold_word = bus_level;
  assign out_connected = !(sleep_lo || sleep_hi);
  always @* begin
    if (host_oe) bus_level = host_data;
    else if (!cs_n && rw) bus_level = hold_word;
    else bus_level = ~last_word; // No pull on the bus, so a released line must not look held
  end
  always @(bus_level) if (host_oe || (!cs_n && rw)) last_word = bus_level;
endmodule
`default_nettype wire

// *** verification/dacl_host_ctrl_tb.sv ***
// Self-checking bench for the converter load controller
`timescale 1ns/1ps
`default_nettype none
module dacl_host_ctrl_tb;
  import dacl_pkg::*;
  logic        core_clk, reset_n, avs_read, avs_write, avs_waitrequest, f;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic        conv_cs_n, conv_rw, conv_data_oe, output_load_strobe, conv_clear_n;
  logic        clear_level_select, sleep_sel_lo, sleep_sel_hi, code_format_sel, out_connected;
  logic [15:0] conv_data_out, conv_data_in, hold_word, out_level, w, exp_lvl;
  int          error_cnt, check_count, seed, n, cyc, wake;
  time         t0;
  dacl_host_ctrl dacl_host_ctrl_inst (.core_clk(core_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_cs_n(conv_cs_n),
    .conv_rw(conv_rw), .conv_data_out(conv_data_out), .conv_data_oe(conv_data_oe),
    .conv_data_in(conv_data_in), .output_load_strobe(output_load_strobe),
    .conv_clear_n(conv_clear_n), .clear_level_select(clear_level_select),
    .sleep_sel_lo(sleep_sel_lo), .sleep_sel_hi(sleep_sel_hi), .code_format_sel(code_format_sel));
  dacl_conv_model dacl_conv_model_inst (.cs_n(conv_cs_n), .rw(conv_rw),
    .host_data(conv_data_out), .host_oe(conv_data_oe), .bus_level(conv_data_in),
    .load_strobe(output_load_strobe), .clear_n(conv_clear_n), .clear_mid(clear_level_select),
    .sleep_lo(sleep_sel_lo), .sleep_hi(sleep_sel_hi), .twos_fmt(code_format_sel),
    .hold_word(hold_word), .out_level(out_level), .out_connected(out_connected));
  // --------
  // Tasks
  // --------
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang(input int k, input int lim);
    if (k >= lim) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 700);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    hang(k, 700);
  endtask
  // Busy covers queued work, so polling it is enough before checking pins
  task automatic idle;
    int k;
    k = 0;
    do begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end while (q[1:0] !== 2'h0 && k < 400);
    hang(k, 400);
  endtask
  function automatic logic [15:0] lvl(input logic [15:0] x, input logic fmt);
    return fmt ? x ^ 16'h8000 : x;
  endfunction
  // --------
  // Sequence
  // --------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    seed = 57;
    error_cnt = 0;
    check_count = 0;
    reset_n = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    chk({sleep_sel_hi, sleep_sel_lo, code_format_sel}, 32'h0);
    chk({out_connected, out_level}, 32'h1_0000);
    bus(1'b1, 3'h6, 32'hFFFF_FFFF);
    bus(1'b0, 3'h7, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    exp_lvl = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h8000 : $random(seed);
      f = $random(seed);
      bus(1'b1, ADDR_CTRL, {31'h0, f});
      bus(1'b1, ADDR_DATA, {16'h0, w});
      idle();
      chk(hold_word, w);
      chk(out_level, exp_lvl);
      bus(1'b1, ADDR_CMD, 32'h1);
      idle();
      exp_lvl = lvl(w, f);
      chk({code_format_sel, out_level}, {f, exp_lvl});
      chk(hold_word, w);
      bus(1'b1, ADDR_CMD, 32'h2);
      idle();
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(q[2], 1'b1);
      bus(1'b0, ADDR_RDATA, 32'h0);
      chk(q, {16'h0, w});
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(q[2], 1'b0);
    end
    w = $random(seed);
    bus(1'b1, ADDR_CTRL, 32'h10);
    bus(1'b1, ADDR_DATA, 32'h1234);
    bus(1'b1, ADDR_DATA, {16'h0, w});
    idle();
    exp_lvl = w;
    chk({hold_word, out_level}, {w, w});
    for (int b = 0; b < 2; b++) begin
      bus(1'b1, ADDR_CTRL, b[0] ? 32'h2 : 32'h0);
      bus(1'b1, ADDR_CMD, 32'h4);
      idle();
      chk({clear_level_select, out_level}, b[0] ? 32'h1_8000 : 32'h0);
      chk(hold_word, w);
      exp_lvl = out_level;
    end
    for (int m = 1; m < 4; m++) begin
      bus(1'b1, ADDR_CTRL, {26'h0, m[0], 1'b0, m[1:0], 2'h0});
      @(posedge core_clk);
      @(posedge core_clk);
      chk({sleep_sel_hi, sleep_sel_lo, out_connected}, {m[1:0], 1'b0});
      w = $random(seed);
      if (w === hold_word) w = ~w;
      wake = m[0] ? WAKE_5V_CYC : WAKE_3V_CYC;
      bus(1'b1, ADDR_CTRL, {26'h0, m[0], 5'h0});
      t0 = $time;
      bus(1'b1, ADDR_DATA, {16'h0, w});
      n = 0;
      while (hold_word !== w && n < 700) begin
        @(posedge core_clk);
        n++;
      end
      hang(n, 700);
      cyc = int'(($time - t0) / 10);
      chk(cyc >= wake && cyc <= wake + 20, 32'h1);
      chk({out_connected, out_level}, {1'b1, exp_lvl});
    end
    complete_run();
  end
endmodule
`default_nettype wire
